// ==== design/bbsc_top.v ====
// Synchronism check stage gating a breaker close, AHB-Lite registers
//
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "bbsc_defs.vh"
module bbsc_top #(
	parameter TICK_MS = `SC_MS_CYCLES
) (
	input  wire        clk_in,                     // 100 MHz clock
	input  wire        nrst_in,                    // Async reset, low
	input  wire        hsel_in,                    // AHB select
	input  wire [31:0] haddr_in,                   // AHB address
	input  wire [1:0]  htrans_in,                  // AHB transfer type
	input  wire        hwrite_in,                  // AHB write
	input  wire [2:0]  hsize_in,                   // AHB size
	input  wire [31:0] hwdata_in,                  // AHB write data
	input  wire        hready_in,                  // AHB bus ready
	output wire        hreadyout_out,              // AHB slave ready
	output wire        hresp_out,                  // AHB response
	output wire [31:0] hrdata_out,                 // AHB read data
	input  wire [7:0]  reference_line_voltage_in,  // Line voltage, % Un
	input  wire [7:0]  reference_phase_voltage_in, // Phase voltage, % Un
	input  wire [7:0]  comparison_line_voltage_in, // Comparison, % Un
	input  wire [19:0] ref_freq_in,                // Reference f, mHz
	input  wire [19:0] cmp_freq_in,                // Comparison f, mHz
	input  wire [8:0]  phase_angle_in,             // Signed angle, deg
	input  wire        close_command_in,           // Mimic/bus close pin
	input  wire        bypass_input_in,            // Bypass input pin
	input  wire        group_change_input_in,      // Group input pin
	input  wire        breaker_closed_in,          // Breaker closed pin
	output wire        breaker_close_out,          // Close to object one
	output wire        request_out,                // Request pending
	output wire        ok_out,                     // Conditions met
	output wire        fail_out                    // Timeout failure
);
	localparam [1:0]  ST_IDLE  = 2'h0;
	localparam [1:0]  ST_WAIT  = 2'h1;
	localparam [1:0]  ST_CLOSE = 2'h2;
	// Cycles per millisecond tick; timeouts count in whole ms
	localparam [16:0] TICK_LAST = TICK_MS[16:0] - 17'h0_0001;

	function hit;
		input [7:0] a;
		input [7:0] ofs;
		begin
			hit = (a == ofs);
		end
	endfunction

	wire [3:0] pins_s;
	wire       cmd_s   = pins_s[0];
	wire       byp_s   = pins_s[1];
	wire       grp_s   = pins_s[2];
	wire       brk_s   = pins_s[3];

	reg        wr_q;
	reg [7:0]  wa_q;
	reg [31:0] rdata_q;
	reg [31:0] ctrl_q;
	reg        man_byp_q;
	reg [31:0] g_lim_q [0:3];
	reg [31:0] g_dfa_q [0:3];
	reg [31:0] g_tim_q [0:3];
	reg [31:0] g_mod_q [0:3];
	reg [1:0]  state_q;
	reg        cmd_q;
	reg        close_q;
	reg        fail_q;
	reg        ok_q;
	reg [15:0] req_cnt_q;
	reg [15:0] sync_cnt_q;
	reg [15:0] fail_cnt_q;
	reg [8:0]  ang_cmd_q;
	reg [8:0]  ang_brk_q;
	reg [16:0] tick_q;
	reg [16:0] acc_q;
	reg [7:0]  pct_q;
	reg [16:0] acc_d;
	reg [7:0]  pct_d;
	integer    i;

	bbsc_sync #(
		.W       (4)
	) u_sync (
		.clk_in  (clk_in),
		.nrst_in (nrst_in),
		.d_in    ({breaker_closed_in, group_change_input_in,
			bypass_input_in, close_command_in}),
		.q_out   (pins_s)
	);

	// Group input overrides the chosen group with the alternate one
	wire [1:0]  grp    = grp_s ? ctrl_q[`SC_CTRL_ALT]
		: ctrl_q[`SC_CTRL_GRP];
	wire [31:0] lim    = g_lim_q[grp];
	wire [31:0] dfa    = g_dfa_q[grp];
	wire [31:0] tim    = g_tim_q[grp];
	wire [31:0] mods   = g_mod_q[grp];
	wire [1:0]  meas   = ctrl_q[`SC_CTRL_MEAS];
	wire        enab   = (meas == `SC_MEAS_LL)
		| (meas == `SC_MEAS_LN);
	wire [7:0]  ref_v  = (meas == `SC_MEAS_LN)
		? reference_phase_voltage_in
		: reference_line_voltage_in;
	wire [19:0] df     = ref_freq_in - cmp_freq_in;
	wire        bypass = byp_s | man_byp_q;
	wire [15:0] tout   = tim[31:16];
	wire [3:0]  dl;
	wire [7:0]  du_abs;
	wire        ok_c;

	bbsc_eval u_eval (
		.ref_v_in     (ref_v),
		.cmp_v_in     (comparison_line_voltage_in),
		.dead_lim_in  (lim[7:0]),
		.live_lim_in  (lim[15:8]),
		.du_lim_in    (lim[23:16]),
		.df_in        (df),
		.df_lim_in    (dfa[15:0]),
		.ang_in       (phase_angle_in),
		.ang_lim_in   (dfa[23:16]),
		.cbt_in       (tim[15:0]),
		.smode_in     (mods[1:0]),
		.umode_in     (mods[4:2]),
		.ref_dead_out (dl[0]),
		.ref_live_out (dl[1]),
		.cmp_dead_out (dl[2]),
		.cmp_live_out (dl[3]),
		.du_abs_out   (du_abs),
		.ok_out       (ok_c)
	);

	// Address phase accepted only with the bus ready
	wire        aphase = hsel_in & htrans_in[1] & hready_in;
	// A request while busy is dropped, never queued
	wire        new_req = (cmd_s & ~cmd_q)
		| (wr_q & hit(wa_q, `SC_CTRL_OFS)
		& hwdata_in[`SC_CTRL_CLOSE]);
	wire        busy   = (state_q != ST_IDLE);
	wire [16:0] to_ext = {1'b0, tout};
	wire        tick   = busy & (tick_q == TICK_LAST);
	wire        timed  = busy & (pct_q >= `SC_PCT_FULL);
	wire [15:0] cbt_w  = (hwdata_in[15:0] < `SC_CBT_MIN) ? `SC_CBT_MIN
		: (hwdata_in[15:0] > `SC_CBT_MAX) ? `SC_CBT_MAX
		: hwdata_in[15:0];

	// Percentage built by repeated subtraction to avoid a divider
	always @*
	begin
		acc_d = acc_q;
		pct_d = pct_q;
		if (tick)
			acc_d = acc_q + `SC_PCT_STEP;
		if (busy && (acc_d >= to_ext) && (pct_q != 8'hFF))
		begin
			acc_d = acc_d - to_ext;
			pct_d = pct_q + 8'h01;
		end
	end

	always @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			wr_q    <= 1'b0;
			wa_q    <= 8'h00;
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			wr_q <= aphase & hwrite_in;
			wa_q <= haddr_in[7:0];
			// A read just after a write to the same word sees the old value
			if (aphase && !hwrite_in)
			begin
				rdata_q <= 32'h0000_0000;
				case (haddr_in[7:0])
				`SC_CTRL_OFS:  rdata_q <= {26'h0, ctrl_q[5:0]};
				`SC_STAT_OFS:  rdata_q <= {15'h0, state_q, 1'b0,
					ok_q, fail_q, 2'h0, dl, grp, bypass,
					fail_q, ok_q, (state_q == ST_WAIT)};
				`SC_BYP_OFS:   rdata_q <= {31'h0, bypass};
				`SC_REQC_OFS:  rdata_q <= {16'h0, req_cnt_q};
				`SC_SYNC_OFS:  rdata_q <= {16'h0, sync_cnt_q};
				`SC_FAILC_OFS: rdata_q <= {16'h0, fail_cnt_q};
				`SC_ANG_OFS:   rdata_q <= {7'h0, ang_brk_q,
					7'h0, ang_cmd_q};
				`SC_PCT_OFS:   rdata_q <= {24'h0, pct_q};
				`SC_DIFF_OFS:  rdata_q <= {df[19:4], 8'h0, du_abs};
				default:
					if (haddr_in[7:6] == 2'h1)
					begin
						case (haddr_in[3:2])
						`SC_GLIM_OFS: rdata_q <= g_lim_q[haddr_in[5:4]];
						`SC_GDFA_OFS: rdata_q <= g_dfa_q[haddr_in[5:4]];
						`SC_GTIM_OFS: rdata_q <= g_tim_q[haddr_in[5:4]];
						default:      rdata_q <= g_mod_q[haddr_in[5:4]];
						endcase
					end
				endcase
			end
		end
	end

	always @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			ctrl_q    <= 32'h0000_0001;
			man_byp_q <= 1'b0;
			for (i = 0; i < 4; i = i + 1)
			begin
				g_lim_q[i] <= `SC_LIM_RST;
				g_dfa_q[i] <= `SC_DFA_RST;
				g_tim_q[i] <= `SC_TIM_RST;
				g_mod_q[i] <= `SC_MOD_RST;
			end
		end
		// Closing time is clamped on write, so no group holds a bad value
		else if (wr_q)
		begin
			if (hit(wa_q, `SC_CTRL_OFS))
				ctrl_q <= {26'h0, hwdata_in[5:0]};
			if (hit(wa_q, `SC_BYP_OFS))
				man_byp_q <= hwdata_in[0];
			if (wa_q[7:6] == 2'h1)
			begin
				case (wa_q[3:2])
				`SC_GLIM_OFS: g_lim_q[wa_q[5:4]] <= {8'h0, hwdata_in[23:0]};
				`SC_GDFA_OFS: g_dfa_q[wa_q[5:4]] <= {8'h0, hwdata_in[23:0]};
				`SC_GTIM_OFS: g_tim_q[wa_q[5:4]] <= {hwdata_in[31:16], cbt_w};
				default:      g_mod_q[wa_q[5:4]] <= {27'h0, hwdata_in[4:0]};
				endcase
			end
		end
	end

	always @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			state_q    <= ST_IDLE;
			cmd_q      <= 1'b0;
			close_q    <= 1'b0;
			fail_q     <= 1'b0;
			ok_q       <= 1'b0;
			req_cnt_q  <= 16'h0000;
			sync_cnt_q <= 16'h0000;
			fail_cnt_q <= 16'h0000;
			ang_cmd_q  <= 9'h000;
			ang_brk_q  <= 9'h000;
			tick_q     <= 17'h0_0000;
			acc_q      <= 17'h0_0000;
			pct_q      <= 8'h00;
		end
		else
		begin
			cmd_q   <= cmd_s;
			ok_q    <= enab & ok_c;
			close_q <= 1'b0;
			tick_q  <= (!busy || tick) ? 17'h0_0000 : tick_q + 17'h0_0001;
			acc_q   <= acc_d;
			pct_q   <= pct_d;
			case (state_q)
			ST_IDLE:
				if (new_req)
				begin
					state_q   <= ST_WAIT;
					fail_q    <= 1'b0;
					acc_q     <= 17'h0_0000;
					pct_q     <= 8'h00;
					req_cnt_q <= req_cnt_q + 16'h0001;
				end
			ST_WAIT:
				if (timed)
				begin
					state_q    <= ST_IDLE;
					fail_q     <= 1'b1;
					fail_cnt_q <= fail_cnt_q + 16'h0001;
				end
				else if (bypass || !enab || ok_q)
				begin
					state_q   <= ST_CLOSE;
					close_q   <= 1'b1;
					ang_cmd_q <= phase_angle_in;
				end
			ST_CLOSE:
				if (brk_s)
				begin
					state_q    <= ST_IDLE;
					ang_brk_q  <= phase_angle_in;
					sync_cnt_q <= sync_cnt_q + 16'h0001;
				end
				// A breaker that never reports closed still fails
				else if (timed)
				begin
					state_q    <= ST_IDLE;
					fail_q     <= 1'b1;
					fail_cnt_q <= fail_cnt_q + 16'h0001;
				end
			default:
				state_q <= ST_IDLE;
			endcase
		end
	end

	// Zero wait states: reads come from the address-phase snapshot
	assign hreadyout_out     = 1'b1;
	assign hresp_out         = 1'b0;
	assign hrdata_out        = rdata_q;
	assign breaker_close_out = close_q;
	assign request_out       = (state_q == ST_WAIT);
	assign ok_out            = ok_q;
	assign fail_out          = fail_q;
endmodule // bbsc_top
`default_nettype wire

// ==== design/bbsc_defs.vh ====
// Constants shared by the synchronism check stage
`ifndef BBSC_DEFS_VH
`define BBSC_DEFS_VH

`define SC_CLK_NS      10
`define SC_MS_NS       1000000
`define SC_MS_CYCLES   (`SC_MS_NS / `SC_CLK_NS)

`define SC_CTRL_OFS    8'h00
`define SC_STAT_OFS    8'h04
`define SC_BYP_OFS     8'h08
`define SC_REQC_OFS    8'h0C
`define SC_SYNC_OFS    8'h10
`define SC_FAILC_OFS   8'h14
`define SC_ANG_OFS     8'h18
`define SC_PCT_OFS     8'h1C
`define SC_DIFF_OFS    8'h20
`define SC_GRP_BASE    8'h40
`define SC_GLIM_OFS    2'h0
`define SC_GDFA_OFS    2'h1
`define SC_GTIM_OFS    2'h2
`define SC_GMOD_OFS    2'h3

`define SC_CTRL_MEAS   1:0
`define SC_CTRL_GRP    3:2
`define SC_CTRL_ALT    5:4
`define SC_CTRL_CLOSE  6

`define SC_MEAS_OFF    2'h0
`define SC_MEAS_LL     2'h1
`define SC_MEAS_LN     2'h2
`define SC_SM_OFF      2'h0
`define SC_SM_ASYNC    2'h1
`define SC_SM_SYNC     2'h2
`define SC_UM_NONE     3'h0
`define SC_UM_DD       3'h1
`define SC_UM_DL       3'h2
`define SC_UM_DLLD     3'h3
`define SC_UM_ALL      3'h4

`define SC_LIM_RST     32'h000A_5014
`define SC_DFA_RST     32'h000A_0064
`define SC_TIM_RST     32'h1388_0064
`define SC_MOD_RST     32'h0000_0002
`define SC_CBT_MIN     16'h0028
`define SC_CBT_MAX     16'h0258
`define SC_PCT_FULL    8'h64
`define SC_PCT_STEP    17'h0_0064
`define SC_DEG_FULL    48'h0000_0000_0168
`define SC_MILLI_SQ    48'h0000_000F_4240

`endif

// ==== design/bbsc_sync.v ====
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module bbsc_sync #(
	parameter W = 1
) (
	input  wire         clk_in,   // System clock
	input  wire         nrst_in,  // Async reset, active low
	input  wire [W-1:0] d_in,     // Asynchronous levels
	output wire [W-1:0] q_out     // Synchronised levels
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	always @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end
		else
		begin
			meta_q <= d_in;
			sync_q <= meta_q;
		end
	end

	assign q_out = sync_q;
endmodule // bbsc_sync
`default_nettype wire

// ==== design/bbsc_eval.v ====
// Combinational amplitude, slip, angle and dead/live evaluation
`timescale 1ns/1ps
`default_nettype none
`include "bbsc_defs.vh"
module bbsc_eval (
	input  wire [7:0]  ref_v_in,     // Reference side voltage, % Un
	input  wire [7:0]  cmp_v_in,     // Comparison side voltage, % Un
	input  wire [7:0]  dead_lim_in,  // Dead voltage limit
	input  wire [7:0]  live_lim_in,  // Live voltage limit
	input  wire [7:0]  du_lim_in,    // Amplitude difference limit
	input  wire [19:0] df_in,        // Signed frequency difference, mHz
	input  wire [15:0] df_lim_in,    // Frequency difference limit, mHz
	input  wire [8:0]  ang_in,       // Signed angle difference, deg
	input  wire [7:0]  ang_lim_in,   // Angle difference limit, deg
	input  wire [15:0] cbt_in,       // Breaker closing time, ms
	input  wire [1:0]  smode_in,     // Synchronism mode
	input  wire [2:0]  umode_in,     // Voltage check mode
	output wire        ref_dead_out, // Reference side dead
	output wire        ref_live_out, // Reference side live
	output wire        cmp_dead_out, // Comparison side dead
	output wire        cmp_live_out, // Comparison side live
	output wire [7:0]  du_abs_out,   // Amplitude difference magnitude
	output wire        ok_out        // Close conditions met
);
	wire [19:0] df_abs  = df_in[19] ? (~df_in + 20'h0_0001) : df_in;
	wire [8:0]  ang_abs = ang_in[8] ? (~ang_in + 9'h001) : ang_in;
	wire        rd = ref_v_in < dead_lim_in;
	wire        rl = ref_v_in > live_lim_in;
	wire        cd = cmp_v_in < dead_lim_in;
	wire        cl = cmp_v_in > live_lim_in;
	wire        du_ok  = du_abs_out <= du_lim_in;
	wire        df_ok  = df_abs <= {4'h0, df_lim_in};
	wire        ang_ok = ang_abs <= {1'b0, ang_lim_in};
	// Angle still to slip versus angle slipped during the closing time
	wire [47:0] ang_term  = {39'h0, ang_abs} * `SC_MILLI_SQ;
	wire [47:0] slip_term = {32'h0, cbt_in} * `SC_DEG_FULL
		* {28'h0, df_abs};
	wire        t_long   = ang_term > slip_term;
	wire        closing  = (ang_abs == 9'h000)
		| ((ang_in[8] != df_in[19]) & (df_abs != 20'h0_0000));
	wire        zero_hit = closing & (ang_term <= slip_term);
	reg         v_ok;
	reg         s_ok;

	assign du_abs_out = (ref_v_in >= cmp_v_in) ? (ref_v_in - cmp_v_in)
		: (cmp_v_in - ref_v_in);
	assign ref_dead_out = rd;
	assign ref_live_out = rl;
	assign cmp_dead_out = cd;
	assign cmp_live_out = cl;

	always @*
	begin
		case (umode_in)
		`SC_UM_DD:   v_ok = rd & cd;
		`SC_UM_DL:   v_ok = rd & cl;
		`SC_UM_DLLD: v_ok = (rd & cl) | (rl & cd);
		`SC_UM_ALL:  v_ok = (rd & cd) | (rd & cl) | (rl & cd);
		default:     v_ok = 1'b0;
		endcase
		case (smode_in)
		`SC_SM_ASYNC: s_ok = rl & cl & du_ok & df_ok & ang_ok & t_long;
		`SC_SM_SYNC:  s_ok = rl & cl & du_ok & df_ok & zero_hit;
		default:      s_ok = 1'b0;
		endcase
	end

	assign ok_out = s_ok | v_ok;
endmodule // bbsc_eval
`default_nettype wire

// ==== test/bbsc_top_assertions.sv ====
// Port-level assertions for the synchronism check stage
`timescale 1ns/1ps
`default_nettype none
module bbsc_chk (
	input wire logic clk_in,            // Clock
	input wire logic nrst_in,           // Reset, low
	input wire logic hreadyout_out,     // Slave ready
	input wire logic hresp_out,         // Response
	input wire logic bypass_input_in,   // Bypass pin
	input wire logic breaker_close_out, // Close pulse
	input wire logic request_out,       // Request
	input wire logic ok_out,            // Conditions met
	input wire logic fail_out           // Timeout
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!nrst_in);
	property p_bus_okay;
		hreadyout_out && !hresp_out;
	endproperty
	a_bus_okay: assert property (p_bus_okay)
		else $error("bus wait or error response");
	property p_close_pulse;
		breaker_close_out |=> !breaker_close_out;
	endproperty
	a_close_pulse: assert property (p_close_pulse)
		else $error("close pulse longer than one cycle");
	property p_close_cause;
		$rose(breaker_close_out) |-> $past(request_out);
	endproperty
	a_close_cause: assert property (p_close_cause)
		else $error("close issued without a request");
	property p_req_drop;
		$fell(request_out) |-> breaker_close_out || fail_out;
	endproperty
	a_req_drop: assert property (p_req_drop)
		else $error("request dropped without close or failure");
	property p_req_hold;
		request_out |=> request_out || breaker_close_out || fail_out;
	endproperty
	a_req_hold: assert property (p_req_hold)
		else $error("request lost while pending");
	property p_fail_hold;
		fail_out |=> fail_out || request_out;
	endproperty
	a_fail_hold: assert property (p_fail_hold)
		else $error("failure cleared without a new request");
	// Pin passes two flops first, so four samples make it visible
	property p_bypass;
		bypass_input_in [*4] ##0 request_out |-> ##[1:2] breaker_close_out;
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("bypassed request not closed");
	property p_ok_close;
		request_out && ok_out |=> breaker_close_out || fail_out;
	endproperty
	a_ok_close: assert property (p_ok_close)
		else $error("conditions met but no close");
endmodule // bbsc_chk
bind bbsc_top bbsc_chk u_chk (.clk_in, .nrst_in, .hreadyout_out, .hresp_out,
	.bypass_input_in, .breaker_close_out, .request_out, .ok_out, .fail_out);
`default_nettype wire

// ==== test/bbsc_obj_model.sv ====
// Behavioural breaker object fed by the stage close pulse
`timescale 1ns/1ps
`default_nettype none
module bbsc_obj_model (
	input  wire logic       clk_in,    // Clock
	input  wire logic       nrst_in,   // Reset, low
	input  wire logic       close_in,  // Close from the stage
	input  wire logic       open_in,   // Open the breaker
	input  wire logic [7:0] dly_in,    // Closing stroke, cycles
	output var  logic       closed_out // Breaker closed
);
	logic [7:0] cnt_q;
	logic       pend_q;
	// Stage pulse is one cycle, so the object keeps its own command
	// until the stroke ends
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			pend_q <= 1'b0;
			cnt_q <= 8'h00;
			closed_out <= 1'b0;
		end
		else if (close_in)
		begin
			pend_q <= 1'b1;
			cnt_q <= dly_in;
		end
		else if (pend_q && cnt_q == 8'h00)
		begin
			pend_q <= 1'b0;
			closed_out <= 1'b1;
		end
		else if (pend_q)
			cnt_q <= cnt_q - 8'h01;
		else if (open_in)
			closed_out <= 1'b0;
	end
endmodule // bbsc_obj_model
`default_nettype wire

// ==== test/bbsc_top_tb.sv ====
// Self-checking bench for the synchronism check stage
`timescale 1ns/1ps
`default_nettype none
`include "bbsc_defs.vh"
module bbsc_top_tb;
	logic        clk_in = 1'b0, nrst_in = 1'b0, hsel_in = 1'b0;
	logic        hwrite_in = 1'b0, cmd = 1'b0, byp = 1'b0, grp = 1'b0;
	logic        opn = 1'b0;
	logic [1:0]  htrans_in = 2'h0;
	logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, rd;
	logic [7:0]  rlv = 8'h00, rpv = 8'h00, clv = 8'h00, dly = 8'h14;
	logic [19:0] rf = 20'h0_0000, cf = 20'h0_0000;
	logic [8:0]  ang = 9'h000;
	wire         hrdy, cls, req, ok, fail, clsd;
	wire  [31:0] hrdata;
	int          miscompares = 0, num_checks = 0;
	bbsc_top #(.TICK_MS(10)) DUT (.clk_in(clk_in), .nrst_in(nrst_in),
		.hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
		.hwrite_in(hwrite_in), .hsize_in(3'h2), .hwdata_in(hwdata_in),
		.hready_in(hrdy), .hreadyout_out(hrdy), .hresp_out(),
		.hrdata_out(hrdata), .reference_line_voltage_in(rlv),
		.reference_phase_voltage_in(rpv), .comparison_line_voltage_in(clv),
		.ref_freq_in(rf), .cmp_freq_in(cf), .phase_angle_in(ang),
		.close_command_in(cmd), .bypass_input_in(byp),
		.group_change_input_in(grp), .breaker_closed_in(clsd),
		.breaker_close_out(cls), .request_out(req), .ok_out(ok),
		.fail_out(fail));
	bbsc_obj_model M (.clk_in(clk_in), .nrst_in(nrst_in), .close_in(cls),
		.open_in(opn), .dly_in(dly), .closed_out(clsd));
	initial
	begin
		forever #5 clk_in = ~clk_in;
	end
	task automatic report_and_stop;
		if (miscompares == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check(logic [31:0] s, e, string m);
		num_checks++;
		if (s !== e)
		begin
			miscompares++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task automatic chk1(logic s, e, string m);
		check({31'h0, s}, {31'h0, e}, m);
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clk_in);
	endtask
	function automatic logic sig(int w);
		case (w)
			0: return hrdy;
			1: return req;
			2: return cls;
			3: return fail;
			default: return clsd;
		endcase
	endfunction
	// Every wait is bounded; running out ends the run as a failure
	task automatic wait_hi(int w, int lim);
		for (int i = 0; i < lim; i++)
		begin
			@(posedge clk_in);
			if (sig(w) === 1'b1)
				return;
		end
		miscompares++;
		report_and_stop();
	endtask
	task automatic bus(logic wr, logic [7:0] a, logic [31:0] wd);
		@(posedge clk_in);
		hsel_in <= 1'b1;
		haddr_in <= {24'h0, a};
		htrans_in <= 2'h2;
		hwrite_in <= wr;
		wait_hi(0, 50);
		hsel_in <= 1'b0;
		htrans_in <= 2'h0;
		hwdata_in <= wd;
		wait_hi(0, 50);
		rd = hrdata;
	endtask
	task automatic rchk(logic [7:0] a, logic [31:0] e, string m);
		bus(1'b0, a, 32'h0);
		check(rd, e, m);
	endtask
	task automatic ask;
		cmd <= 1'b1;
		wait_hi(1, 10);
		cmd <= 1'b0;
	endtask
	task automatic open_cb;
		wait_hi(4, 60);
		tick(4);
		opn <= 1'b1;
		tick(1);
		opn <= 1'b0;
		tick(4);
	endtask
	task automatic t_reset;
		rchk(8'h00, 32'h0000_0001, "ctrl reset");
		for (logic [7:0] b = 8'h40; b < 8'h80; b += 8'h10)
		begin
			rchk(b, `SC_LIM_RST, "limit reset");
			rchk(b + 8'h04, `SC_DFA_RST, "slip reset");
			rchk(b + 8'h08, `SC_TIM_RST, "time reset");
			rchk(b + 8'h0C, `SC_MOD_RST, "mode reset");
		end
		rchk(8'h08, 32'h0, "bypass reset");
		rchk(8'h0C, 32'h0, "counter reset");
		rchk(8'h30, 32'h0, "unmapped read");
		bus(1'b1, 8'h48, 32'h0014_000A);
		rchk(8'h48, 32'h0014_0028, "closing time low");
		bus(1'b1, 8'h48, 32'h0014_03E8);
		rchk(8'h48, 32'h0014_0258, "closing time high");
		bus(1'b1, 8'h48, 32'h0014_0064);
	endtask
	task automatic t_volt;
		logic [23:0] tc [8] = '{24'h10_A0A1, 24'h10_A5A0, 24'h20_A5A1,
			24'h25_A0A0, 24'h35_A0A1, 24'h40_A0A1, 24'h45_A5A0, 24'h40_A320};
		rf <= 20'd50000;
		cf <= 20'd51000;
		ang <= 9'd90;
		foreach (tc[i])
		begin
			bus(1'b1, 8'h4C, {27'h0, tc[i][22:20], 2'h0});
			rlv <= tc[i][19:12];
			clv <= tc[i][11:4];
			tick(4);
			chk1(ok, tc[i][0], "voltage check");
		end
		bus(1'b1, 8'h4C, 32'h0000_0008);
		rlv <= 8'd90;
		rpv <= 8'd10;
		clv <= 8'd90;
		bus(1'b1, 8'h00, 32'h0000_0002);
		tick(4);
		chk1(ok, 1'b1, "phase reference");
		bus(1'b1, 8'h00, 32'h0000_0001);
		tick(4);
		chk1(ok, 1'b0, "line reference");
		bus(1'b1, 8'h00, 32'h0000_0000);
		tick(4);
		chk1(ok, 1'b0, "check off");
		bus(1'b1, 8'h00, 32'h0000_0001);
		rlv <= 8'd10;
		ask();
		wait_hi(2, 20);
		chk1(req, 1'b0, "request after close");
		ang <= 9'd45;
		open_cb();
		rchk(8'h18, 32'h002D_005A, "recorded angles");
	endtask
	task automatic t_fail;
		bus(1'b1, 8'h4C, 32'h0000_0004);
		rlv <= 8'd90;
		ask();
		tick(50);
		chk1(req, 1'b1, "request held");
		wait_hi(3, 400);
		chk1(req, 1'b0, "request at timeout");
		tick(20);
		chk1(fail, 1'b1, "fail held");
		rchk(8'h1C, {24'h0, `SC_PCT_FULL}, "elapsed percent");
	endtask
	task automatic t_bypass;
		bus(1'b1, 8'h08, 32'h0000_0001);
		rchk(8'h08, 32'h0000_0001, "manual bypass");
		dly <= 8'd1;
		ask();
		wait_hi(2, 20);
		chk1(fail, 1'b0, "fail cleared");
		open_cb();
		bus(1'b1, 8'h08, 32'h0000_0000);
		byp <= 1'b1;
		tick(4);
		rchk(8'h08, 32'h0000_0001, "pin bypass");
		ask();
		wait_hi(2, 20);
		open_cb();
		byp <= 1'b0;
		rchk(8'h0C, 32'h0000_0004, "requests");
		rchk(8'h10, 32'h0000_0003, "closes");
		rchk(8'h14, 32'h0000_0001, "failures");
	endtask
	task automatic t_sync;
		logic [31:0] tc [7] = '{32'h1050_0001, 32'h1140_0000, 32'h1050_0C80,
			32'h1020_05A0, 32'h1050_0321, 32'h21E0_05A0, 32'h2010_05A1};
		clv <= 8'd90;
		rf <= 20'd50000;
		foreach (tc[i])
		begin
			bus(1'b1, 8'h4C, {30'h0, tc[i][29:28]});
			ang <= {1'b0, tc[i][27:20]};
			cf <= 20'd50000 + {4'h0, tc[i][19:4]};
			tick(4);
			chk1(ok, tc[i][0], "slip and angle");
		end
		rchk(8'h20, 32'hFFFA_0000, "frequency difference");
		bus(1'b1, 8'h00, 32'h0000_0011);
		grp <= 1'b1;
		tick(4);
		bus(1'b0, 8'h04, 32'h0);
		check({30'h0, rd[5:4]}, 32'h1, "pin group");
		grp <= 1'b0;
		bus(1'b1, 8'h00, 32'h0000_0009);
		bus(1'b0, 8'h04, 32'h0);
		check({30'h0, rd[5:4]}, 32'h2, "set group");
		bus(1'b1, 8'h00, 32'h0000_0049);
		wait_hi(2, 20);
		chk1(req, 1'b0, "register request closed");
		open_cb();
		rchk(8'h0C, 32'h0000_0005, "register request");
		rchk(8'h10, 32'h0000_0004, "synchronised close");
	endtask
	initial
	begin
		tick(8);
		nrst_in <= 1'b1;
		t_reset();
		t_volt();
		t_fail();
		t_bypass();
		t_sync();
		report_and_stop();
	end
endmodule // bbsc_top_tb
`default_nettype wire
